// ===== verilog/adc_port_map.svh
// Purpose: register offsets, reset values and timing counts of the converter port
// Assumes: 10 MHz core clock
// Notes: definitions only
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

// register byte offsets on the bus
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CFG 8'h08
`define ADDR_RESULT 8'h0c

// timing
`define CLK_PERIOD_NS 100
`define CONV_DURATION_NS 2200
`define CONV_CYCLES ((`CONV_DURATION_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// reset values
`define CFG_RST 14'h0001
`define CTRL_RST 8'h16

// configuration word and transfer lengths
`define CFG_BITS 4'd14
`define CFG_LAST_BIT 4'd13
`define XFER_PLAIN 5'd16
`define XFER_RB 5'd30

// sequencer field codes
`define SEQ_OFF 2'b00
`define SEQ_UPD 2'b01
`define SEQ_TEMP 2'b10
`define SEQ_NOTEMP 2'b11

`endif

// ===== verilog/adc_port_pkg.sv
// Purpose: types shared by the converter port modules
// Assumes: nothing
// Notes: each module keeps its state in one of these structs, except the reset flops of adc_port_top
package adc_port_pkg;

  typedef struct packed {
    logic wr_cfg;
    logic incc_hi;
    logic single;
    logic incc_lo;
    logic [2:0] last_ch;
    logic bw;
    logic [2:0] ref_sel;
    logic [1:0] seq;
    logic readback_disable_bit;
  } cfg_t;

  typedef enum logic {PH_ACQ, PH_CONV} phase_t;

  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
    logic rise;
    logic fall;
  } sync_t;

  typedef struct packed {
    logic [2:0] chan;
    logic temp;
  } seq_st_t;

  typedef struct packed {
    phase_t ph;
    logic [7:0] conv_cnt;
    logic [7:0] conv_cyc;
    logic busy_mode;
    cfg_t cfg;
    cfg_t cfg_pend;
    logic pend_vld;
    logic [13:0] cap_sh;
    logic [3:0] cap_cnt;
    logic [29:0] out_sh;
    logic [4:0] fall_cnt;
    logic out_armed;
    logic busy_first;
    logic rb_en;
    logic result_serial_output;
    logic sdo_oe;
    logic [15:0] last_result;
    logic step;
    logic restart;
    logic converting;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hready;
  } port_st_t;

endpackage

// ===== verilog/seq_if.sv
// Purpose: links the port controller to the channel sequencer
// Assumes: one clock shared by both ends
// Notes: step and restart are one-cycle pulses
`timescale 1ns/1ps
interface seq_if;
  logic step;
  logic restart;
  logic [1:0] seq_mode;
  logic single;
  logic [2:0] last_ch;
  logic [2:0] chan;
  logic temp;

  modport ctrl (output step, output restart, output seq_mode, output single,
    output last_ch, input chan, input temp);
  modport seq (input step, input restart, input seq_mode, input single,
    input last_ch, output chan, output temp);
endinterface

// ===== verilog/pin_sync.sv
// Purpose: three-stage synchroniser with filtered level and edge pulses
// Assumes: pin is asynchronous to clk
// Notes: a change counts once the second and third stages agree
`timescale 1ns/1ps
module pin_sync
  import adc_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin
  input wire logic pin,
  // filtered view
  output logic level,
  output logic rise,
  output logic fall
);
  sync_t q;
  sync_t d;

  always_comb begin
    d = q;
    // first stage feeds only the second
    d.sh = {q.sh[1:0], pin};
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (q.sh[1] == q.sh[2] && q.sh[2] != q.lvl) begin
      d.lvl = q.sh[2];
      d.rise = q.sh[2];
      d.fall = ~q.sh[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
  assign rise = q.rise;
  assign fall = q.fall;
endmodule // pin_sync

// ===== verilog/chan_sequencer.sv
// Purpose: channel pointer that steps once per finished conversion
// Assumes: step pulses come one per end of conversion
// Notes: the pointer names the input acquired for the next conversion
`timescale 1ns/1ps
module chan_sequencer
  import adc_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controller side
  seq_if.seq s
);
  `include "adc_port_map.svh"

  seq_st_t q;
  seq_st_t d;
  logic at_last;

  always_comb begin
    d = q;
    // pairs run on even inputs; a last setting of 110 or 111 ends at pair 6
    at_last = s.single ? (q.chan >= s.last_ch) : (q.chan >= {s.last_ch[2:1], 1'b0});
    if (s.step) begin
      if (s.seq_mode == `SEQ_OFF) begin
        // sequencer off: the selected input is converted every time
        d.chan = s.last_ch;
        d.temp = 1'b0;
      end else if (s.restart) begin
        d.chan = 3'h0;
        d.temp = 1'b0;
      end else if (q.temp) begin
        d.chan = 3'h0;
        d.temp = 1'b0;
      end else if (at_last) begin
        d.chan = 3'h0;
        d.temp = (s.seq_mode == `SEQ_TEMP);
      end else begin
        d.chan = q.chan + (s.single ? 3'h1 : 3'h2);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s.chan = q.chan;
  assign s.temp = q.temp;
endmodule // chan_sequencer

// ===== verilog/adc_port_top.sv
// Purpose: serial port, conversion timing and sequencer control of the converter
// Assumes: 10 MHz CLOCK; serial clock well below CLOCK/6; AHB-Lite single word access
// Notes: result data come from the core on SAMPLE_DATA at end of conversion
//
// Functional notes
// - Sequencer scans from input zero to the last-channel field, then repeats.
// - Pairs use even inputs positive, odd negative; 110 or 111 scans four pairs.
// - Bits two and one of the configuration enable or disable the sequencer.
// - Codes: 00 off, 01 update during sequence, 10 with sensor, 11 without.
// - Changing pairing or last channel restarts the sequence at input zero.
// - After the last channel the sensor slot follows if enabled, then input zero.
// - Word written in phase n-1 applies at phase n; valid data in n+1.
// - Convert pin rise starts conversion, floats output, ignores configuration input.
// - A conversion runs to its end whatever the convert pin does.
// - Convert pin falling after conversion puts the result MSB on the output.
// - While convert pin low, first 14 serial clock rises capture configuration bits.
// - Without busy, first 15 falling edges shift out bits after the MSB.
// - A configuration word incomplete by end of conversion is dropped.
// - A result not fully read by the next end of conversion is lost.
// - Without busy, output floats on 16th or 30th fall or convert rise.
// - With readback, the associated configuration follows the result LSB, MSB first.
// - Output data stay valid across both serial clock edges.
// - In busy mode the output goes low at end of conversion as data ready.
// - Busy mode with readback needs 31 falling edges before output floats.
// - Busy mode without readback needs 17 falling edges; last bit stays driven.
`timescale 1ns/1ps
module adc_port_top
  import adc_port_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // host serial pins
  input wire logic CONVERT_PIN,
  input wire logic SERIAL_CLOCK,
  input wire logic CONFIG_IN,
  output logic RESULT_SERIAL_OUTPUT_O,
  output logic RESULT_SERIAL_OUTPUT_OE,
  // converter core
  input wire logic [15:0] SAMPLE_DATA,
  output logic [2:0] CHANNEL_SEL,
  output logic TEMP_SEL,
  output logic SINGLE_SEL,
  output logic CONVERTING
);
  `include "adc_port_map.svh"

  logic [1:0] rst_sync_q;
  logic rst_n;
  port_st_t q;
  port_st_t d;
  logic cnv_lvl;
  logic cnv_rise;
  logic cnv_fall;
  logic sck_rise;
  logic sck_fall;
  logic din_lvl;
  logic eoc;
  logic [4:0] total;
  logic addr_hit;
  cfg_t word_in;

  seq_if sif ();

  // reset release through two flops
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  pin_sync u_cnv_sync (
    .clk(CLOCK),
    .rst_n(rst_n),
    .pin(CONVERT_PIN),
    .level(cnv_lvl),
    .rise(cnv_rise),
    .fall(cnv_fall)
  );

  pin_sync u_sck_sync (
    .clk(CLOCK),
    .rst_n(rst_n),
    .pin(SERIAL_CLOCK),
    .level(),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  // same depth as the serial clock path so the bit lines up with its edge
  pin_sync u_din_sync (
    .clk(CLOCK),
    .rst_n(rst_n),
    .pin(CONFIG_IN),
    .level(din_lvl),
    .rise(),
    .fall()
  );

  chan_sequencer u_seq (
    .clk(CLOCK),
    .rst_n(rst_n),
    .s(sif.seq)
  );

  assign eoc = (q.ph == PH_CONV) && (q.conv_cnt == 8'h01);
  assign word_in = cfg_t'({q.cap_sh[12:0], din_lvl});

  always_comb begin
    d = q;
    d.step = 1'b0;
    d.restart = 1'b0;
    total = q.rb_en ? `XFER_RB : `XFER_PLAIN;
    if (q.busy_mode) begin
      // one extra edge: the first fall only replaces the data-ready low
      total = total + 5'd1;
    end
    addr_hit = (HADDR[31:8] == 24'h000000);

    // bus address phase, zero wait states
    d.hready = 1'b1;
    d.a_wr = 1'b0;
    if (HREADY) begin
      d.a_wr = HSEL && HTRANS[1] && HWRITE && addr_hit;
      d.a_addr = HADDR[7:0];
      if (HSEL && HTRANS[1] && !HWRITE && addr_hit) begin
        case (HADDR[7:0])
          `ADDR_CTRL: d.hrdata = {24'h000000, q.conv_cyc};
          `ADDR_STATUS: d.hrdata = {20'h00000, q.converting, q.busy_mode, q.pend_vld,
            q.sdo_oe, q.cap_cnt, sif.temp, sif.chan};
          `ADDR_CFG: d.hrdata = {18'h00000, q.cfg};
          `ADDR_RESULT: d.hrdata = {16'h0000, q.last_result};
          default: d.hrdata = 32'h00000000;
        endcase
      end else begin
        d.hrdata = 32'h00000000;
      end
    end
    // bus data phase
    if (q.a_wr && q.a_addr == `ADDR_CTRL) begin
      // zero would wrap the conversion timer to 256 cycles, so one cycle is the floor
      d.conv_cyc = (HWDATA[7:0] == 8'h00) ? 8'h01 : HWDATA[7:0];
    end

    // conversion timer
    if (q.ph == PH_CONV) begin
      d.conv_cnt = q.conv_cnt - 8'h01;
    end else if (cnv_rise) begin
      d.ph = PH_CONV;
      d.conv_cnt = q.conv_cyc;
      d.converting = 1'b1;
    end

    // serial output: data move only on falling edges
    if (cnv_rise) begin
      d.sdo_oe = 1'b0;
      d.out_armed = 1'b0;
    end else if (cnv_fall && q.out_armed && q.ph == PH_ACQ) begin
      d.result_serial_output = q.out_sh[29];
      d.sdo_oe = 1'b1;
      d.out_armed = 1'b0;
    end else if (sck_fall && !cnv_lvl && q.sdo_oe) begin
      d.fall_cnt = q.fall_cnt + 5'd1;
      if (q.busy_first) begin
        d.busy_first = 1'b0;
        d.result_serial_output = q.out_sh[29];
      end else begin
        d.out_sh = {q.out_sh[28:0], 1'b0};
        d.result_serial_output = q.out_sh[28];
      end
      if (d.fall_cnt == total) begin
        d.sdo_oe = 1'b0;
      end
    end

    // configuration capture on rising edges while convert pin is low
    if (sck_rise && !cnv_lvl) begin
      if (q.cap_cnt != 4'h0 && q.cap_cnt < `CFG_BITS) begin
        d.cap_sh = {q.cap_sh[12:0], din_lvl};
        d.cap_cnt = q.cap_cnt + 4'h1;
        if (q.cap_cnt == `CFG_LAST_BIT) begin
          d.cfg_pend = word_in;
          d.pend_vld = 1'b1;
        end
      end else if (din_lvl) begin
        // a word opens only on a high bit, so a host holding the line low keeps the old word
        d.cap_sh = {13'h0000, 1'b1};
        d.cap_cnt = 4'h1;
        d.pend_vld = 1'b0;
      end
    end

    // end of conversion: new result replaces any unread one
    if (eoc) begin
      d.ph = PH_ACQ;
      d.converting = 1'b0;
      d.out_sh = {SAMPLE_DATA, q.cfg};
      d.last_result = SAMPLE_DATA;
      d.rb_en = ~q.cfg.readback_disable_bit;
      d.fall_cnt = 5'd0;
      d.busy_mode = ~cnv_lvl;
      if (!cnv_lvl) begin
        d.result_serial_output = 1'b0;
        d.sdo_oe = 1'b1;
        d.busy_first = 1'b1;
        d.out_armed = 1'b0;
      end else begin
        d.sdo_oe = 1'b0;
        d.busy_first = 1'b0;
        d.out_armed = 1'b1;
      end
      // a partial word is dropped; a complete one takes effect now
      d.cap_cnt = 4'h0;
      d.pend_vld = 1'b0;
      if (q.pend_vld) begin
        d.cfg = q.cfg_pend;
        d.restart = (q.cfg_pend.single != q.cfg.single) ||
          (q.cfg_pend.last_ch != q.cfg.last_ch) ||
          (q.cfg.seq == `SEQ_OFF);
      end
      d.step = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.cfg <= cfg_t'(`CFG_RST);
      q.conv_cyc <= `CTRL_RST;
      q.hready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // sequencer follows the configuration now in force
  assign sif.step = q.step;
  assign sif.restart = q.restart;
  assign sif.seq_mode = q.cfg.seq;
  assign sif.single = q.cfg.single;
  assign sif.last_ch = q.cfg.last_ch;

  assign HRDATA = q.hrdata;
  assign HREADYOUT = q.hready;
  assign HRESP = 1'b0;
  assign RESULT_SERIAL_OUTPUT_O = q.result_serial_output;
  assign RESULT_SERIAL_OUTPUT_OE = q.sdo_oe;
  assign CHANNEL_SEL = sif.chan;
  assign TEMP_SEL = sif.temp;
  assign SINGLE_SEL = q.cfg.single;
  assign CONVERTING = q.converting;
endmodule // adc_port_top

// ===== verif/adc_port_properties.sv
// Purpose: pin-level checks of the converter port
// Assumes: pins reach the core through a three-stage synchroniser
// Notes: bound to adc_port_top below
`timescale 1ns/1ps
module adc_port_properties (
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // watched ports
  input wire logic HREADYOUT,
  input wire logic CONVERT_PIN,
  input wire logic RESULT_SERIAL_OUTPUT_O,
  input wire logic RESULT_SERIAL_OUTPUT_OE,
  input wire logic CONVERTING
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  a_bus_ready: assert property (HREADYOUT)
    else $error("slave inserted a wait state");
  a_conv_float: assert property (
    CONVERTING && $past(CONVERTING) |-> !RESULT_SERIAL_OUTPUT_OE)
    else $error("output driven during conversion");
  a_conv_hold: assert property ($rose(CONVERTING) |-> CONVERTING[*8])
    else $error("conversion cut short");
  a_conv_ends: assert property ($rose(CONVERTING) |-> ##[1:300] !CONVERTING)
    else $error("conversion never ends");
  a_plain_eoc: assert property (
    $fell(CONVERTING) && CONVERT_PIN && $past(CONVERT_PIN, 6)
    |=> (!RESULT_SERIAL_OUTPUT_OE)[*2])
    else $error("output driven at end of conversion without busy");
  a_busy_eoc: assert property (
    $fell(CONVERTING) && !CONVERT_PIN && !$past(CONVERT_PIN, 6)
    |-> ##[0:1] (RESULT_SERIAL_OUTPUT_OE && !RESULT_SERIAL_OUTPUT_O))
    else $error("no data ready at end of conversion");
  a_cnv_release: assert property (
    $rose(CONVERT_PIN) |-> ##[1:6] !RESULT_SERIAL_OUTPUT_OE)
    else $error("output still driven after convert rise");
  a_drive_cause: assert property (
    $rose(RESULT_SERIAL_OUTPUT_OE) |-> !CONVERT_PIN && !$past(CONVERT_PIN, 2))
    else $error("output enabled while convert high");
endmodule // adc_port_properties

bind adc_port_top adc_port_properties adc_port_properties_i (
  .CLOCK,
  .ARST_N,
  .HREADYOUT,
  .CONVERT_PIN,
  .RESULT_SERIAL_OUTPUT_O,
  .RESULT_SERIAL_OUTPUT_OE,
  .CONVERTING
);

// ===== verif/host_model.sv
// Purpose: host serial controller for convert, serial clock and configuration pins
// Assumes: serial clock of 800 ns, eight core clocks
// Notes: the output line has a pull-up, so a released line reads high
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic convert_pin,
  output logic sck,
  output logic din,
  input wire logic result_serial_output
);
  initial begin
    convert_pin = 1'b0;
    sck = 1'b0;
    din = 1'b0;
  end
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // busy: convert dropped during the conversion so its end raises data ready
  task convert(input logic busy);
    wt(1);
    convert_pin <= 1'b1;
    sck <= busy;
    wt(5);
    convert_pin <= !busy;
    wt(30);
    convert_pin <= 1'b0;
    wt(8);
  endtask
  task xfer(input logic busy, input int nb, input logic [13:0] cw, input int nc,
    output logic [29:0] rd);
    rd = '0;
    for (int i = 0; i < nb; i++) begin
      if (busy) sck <= 1'b0;
      din <= (i < nc) ? cw[13 - i] : 1'b0;
      wt(4);
      sck <= 1'b1;
      wt(4);
      // taken just before the fall: the port moves its bit some core clocks after each fall
      rd = {rd[28:0], result_serial_output};
      if (!busy) sck <= 1'b0;
    end
    // one extra fall in busy mode releases the last bit
    if (busy) begin
      sck <= 1'b0;
      wt(4);
      sck <= 1'b1;
    end
    wt(8);
  endtask
endmodule // host_model

// ===== verif/testbench.sv
// Purpose: self-checking bench of the converter port
// Assumes: 10 MHz clock, serial clock of eight core clocks
// Notes: expectations follow from the configuration words the bench sends
`timescale 1ns/1ps
`include "adc_port_map.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module testbench;
  localparam logic [13:0] w_seq = 14'h3dc4;
  localparam logic [13:0] w_pair = 14'h37c7;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] sample = 16'h0;
  logic [31:0] hrdata;
  logic [2:0] chan;
  logic hrdy, hresp, sdo_o, sdo_oe, temp, single, conv, convert_pin, sck, din;
  int miscompares = 0;
  int n_tests = 0;
  wire result_serial_output = sdo_oe ? sdo_o : 1'b1;
  always #50 clock = ~clock;
  adc_port_top adc_port_top_i (.CLOCK(clock), .ARST_N(arst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
    .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(hresp), .CONVERT_PIN(convert_pin), .SERIAL_CLOCK(sck), .CONFIG_IN(din),
    .RESULT_SERIAL_OUTPUT_O(sdo_o), .RESULT_SERIAL_OUTPUT_OE(sdo_oe),
    .SAMPLE_DATA(sample), .CHANNEL_SEL(chan), .TEMP_SEL(temp),
    .SINGLE_SEL(single), .CONVERTING(conv));
  host_model host_model_i (.clk(clock), .convert_pin(convert_pin), .sck(sck), .din(din), .result_serial_output(result_serial_output));
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clock);
    while (hrdy !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hrdy !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask
  task step(input logic [15:0] smp, input int nb, input logic [13:0] cw,
    input int nc, output logic [29:0] rd);
    sample <= smp;
    host_model_i.convert(1'b0);
    host_model_i.xfer(1'b0, nb, cw, nc, rd);
  endtask
  task t_regs;
    logic [31:0] r;
    bus(0, `ADDR_CTRL, 0, r);
    `CHK("ctrl reset", {24'h0, `CTRL_RST}, r)
    bus(1, `ADDR_CTRL, 32'h20, r);
    bus(0, `ADDR_CTRL, 0, r);
    `CHK("ctrl write", 32'h20, r)
    bus(1, `ADDR_CTRL, {24'h0, `CTRL_RST}, r);
    bus(1, `ADDR_CFG, 32'h3fff, r);
    bus(0, `ADDR_CFG, 0, r);
    `CHK("cfg read only", {18'h0, `CFG_RST}, r)
    bus(0, 32'h100, 0, r);
    `CHK("unmapped", 32'h0, r)
    `CHK("okay response", 1'b0, hresp)
    $display("registers done");
  endtask
  task t_seq;
    logic [29:0] rd;
    logic [15:0] smp;
    logic [2:0] ch [7] = '{0, 0, 1, 2, 3, 0, 0};
    for (int k = 0; k < 7; k++) begin
      smp = 16'h8e31 + 16'(k);
      step(smp, (k > 0) ? 30 : 16, w_seq, (k < 2) ? 14 : 0, rd);
      `CHK("sensor slot", k == 5, temp)
      if (k != 5) `CHK("channel", ch[k], chan)
      `CHK("result", smp, (k > 0) ? rd[29:14] : rd[15:0])
      if (k > 1) `CHK("readback", w_seq, rd[13:0])
      `CHK("released", 1'b0, sdo_oe)
    end
    $display("sequence done");
  endtask
  task t_pair;
    logic [29:0] rd;
    logic [2:0] ch [6] = '{1, 0, 2, 4, 6, 0};
    for (int k = 0; k < 6; k++) begin
      step(16'h0f0f, (k == 0) ? 30 : 16, w_pair, (k == 0) ? 14 : 0, rd);
      `CHK("pair channel", ch[k], chan)
      `CHK("single", k == 0, single)
      `CHK("no sensor", 1'b0, temp)
    end
    $display("pairs done");
  endtask
  task t_drop;
    logic [29:0] rd;
    logic [31:0] r;
    step(16'h1111, 10, 14'h3fff, 10, rd);
    step(16'h2222, 16, 14'h0, 0, rd);
    bus(0, `ADDR_CFG, 0, r);
    `CHK("cfg kept", {18'h0, w_pair}, r)
    `CHK("no restart", 3'h4, chan)
    `CHK("next result", 16'h2222, rd[15:0])
    bus(0, `ADDR_STATUS, 0, r);
    `CHK("status idle", 32'h4, r)
    bus(0, `ADDR_RESULT, 0, r);
    `CHK("result reg", 32'h2222, r)
    $display("drop done");
  endtask
  task t_busy;
    logic [29:0] rd;
    sample <= 16'hc35a;
    host_model_i.convert(1'b1);
    `CHK("data ready drive", 1'b1, sdo_oe)
    `CHK("data ready low", 1'b0, result_serial_output)
    host_model_i.xfer(1'b1, 16, 14'h0, 0, rd);
    `CHK("busy result", 16'hc35a, rd[15:0])
    `CHK("busy released", 1'b0, sdo_oe)
    $display("busy done");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    t_regs;
    t_seq;
    t_pair;
    t_drop;
    t_busy;
    print_verdict;
  end
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    print_verdict;
  end
endmodule // testbench
